//--- clk_sel_pkg.sv
// Functional notes
// - At or above 100 MHz core clock, flash reads use two wait cycles.
// - Zero-wait flash reads are refused and flagged at or above 50 MHz.
// - Sub-clock runs when system-use or RTC-count request is set or it is the active source, else stopped.
// - PLL derives from main oscillator, input divide one, multiply ten.
// - Reset selects PLL, main running, sub-clock and fast oscillator stopped.
// - RTC sub-clock request works whatever the system source is.
// - Main or sub source gives low-speed mode one; PLL or fast gives high-speed.
package clk_sel_pkg;

  // ****************************************************************
  // Register map and bus answers.
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] FLASH_OFFSET  = 8'h04;
  localparam logic [7:0] POWER_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // Source, flash wait and power mode codes.
  // ****************************************************************
  localparam logic [1:0] SOURCE_CODE_MAIN     = 2'h0;
  localparam logic [1:0] SOURCE_CODE_FAST_OSC = 2'h1;
  localparam logic [1:0] SOURCE_CODE_PLL      = 2'h2;
  localparam logic [1:0] SOURCE_CODE_SUB      = 2'h3;
  localparam logic [1:0] FLASH_ZERO_WAIT_CODE = 2'h0;
  localparam logic [1:0] FLASH_ONE_WAIT_CODE  = 2'h1;
  localparam logic [1:0] FLASH_TWO_WAIT_CODE  = 2'h2;
  localparam logic [1:0] HIGH_SPEED_POWER_CODE     = 2'h0;
  localparam logic [1:0] LOW_SPEED_ONE_POWER_CODE  = 2'h1;

  // ****************************************************************
  // Clock figures in hertz.
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MAIN_HZ         = 24_000_000;
  localparam int unsigned FAST_OSC_HZ     = 20_000_000;
  localparam int unsigned SUB_HZ          = 32_768;
  localparam int unsigned PLL_IN_DIV      = 1;
  localparam int unsigned PLL_MULT        = 10;
  localparam int unsigned PLL_CORE_DIV    = 2;
  localparam int unsigned MAIN_CORE_DIV   = 32;
  localparam int unsigned TWO_WAIT_MIN_HZ = 100_000_000;
  localparam int unsigned ZERO_WAIT_MAX_HZ = 50_000_000;
  localparam logic [3:0]  PLL_IN_DIV_CODE = 4'h1;
  localparam logic [5:0]  PLL_MULT_CODE   = 6'h0a;

  // ****************************************************************
  // Stabilization times and their cycle counts (least times round up).
  // ****************************************************************
  localparam int unsigned MAIN_STAB_US = 4200;
  localparam int unsigned SUB_STAB_MS  = 1300;
  localparam int unsigned PLL_STAB_US  = 100;
  localparam int unsigned FAST_STAB_US = 100;
  localparam int unsigned CYC_PER_US   = (CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned MAIN_STAB_CYC = MAIN_STAB_US * CYC_PER_US;
  localparam int unsigned SUB_STAB_CYC  = SUB_STAB_MS * 1000 * CYC_PER_US;
  localparam int unsigned PLL_STAB_CYC  = PLL_STAB_US * CYC_PER_US;
  localparam int unsigned FAST_STAB_CYC = FAST_STAB_US * CYC_PER_US;

  // ****************************************************************
  // Register layouts.
  // ****************************************************************
  typedef struct packed {
    logic       rtc_req;
    logic       sub_req;
    logic       fast_en;
    logic       pll_en;
    logic       main_en;
    logic [1:0] rsvd;
    logic [1:0] src;
  } ctrl_t;

  typedef struct packed {
    logic       viol;
    logic       pending;
    logic [3:0] stable;
    logic [1:0] active;
  } status_t;

  localparam logic [8:0] CTRL_RESET     = 9'h032;
  localparam logic [8:0] CTRL_WR_MASK   = 9'h1f3;
  localparam int unsigned VIOL_BIT      = 7;

endpackage

//--- osc_stab_timer.sv
`timescale 1ns/1ps
module osc_stab_timer #(
  parameter int unsigned COUNT = 16
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      stable
);

  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt_q;

  // Counts enabled cycles; any stop restarts the wait from zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (!stable) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Declares the source usable once the count has run out.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stable <= 1'b0;
    end else if (!run) begin
      stable <= 1'b0;
    end else if (cnt_q == LAST) begin
      stable <= 1'b1;
    end
  end

endmodule

//--- system_clock_source_select.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module system_clock_source_select
  import clk_sel_pkg::*;
#(
  parameter int unsigned MAIN_STAB = MAIN_STAB_CYC,
  parameter int unsigned SUB_STAB  = SUB_STAB_CYC,
  parameter int unsigned PLL_STAB  = PLL_STAB_CYC,
  parameter int unsigned FAST_STAB = FAST_STAB_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             main_osc_en,
  output logic             pll_en,
  output logic [3:0]       pll_in_div,
  output logic [5:0]       pll_mult,
  output logic             internal_fast_oscillator_en,
  output logic             sub_osc_en,
  output logic [1:0]       system_source_select,
  output logic [1:0]       power_mode_setting,
  output logic [1:0]       flash_wait_setting,
  output logic [31:0]      core_system_clock_hz
);

  typedef enum logic {SW_IDLE, SW_WAIT} sw_state_t;

  // ****************************************************************
  // State.
  // ****************************************************************
  ctrl_t       ctrl_q;
  logic [1:0]  flash_req_q;
  logic        viol_q;
  logic [1:0]  active_q;
  sw_state_t   sw_q;
  logic [3:0]  stable;
  logic [3:0]  osc_on;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic [31:0] target_hz;
  logic [1:0]  flash_need;
  status_t     status;

  // Core frequency that each source gives at the fixed dividers.
  function automatic logic [31:0] freq_of(input logic [1:0] src);
    case (src)
      SOURCE_CODE_MAIN:     freq_of = 32'(MAIN_HZ / MAIN_CORE_DIV);
      SOURCE_CODE_FAST_OSC: freq_of = 32'(FAST_OSC_HZ);
      SOURCE_CODE_PLL:      freq_of = 32'(MAIN_HZ / PLL_IN_DIV * PLL_MULT / PLL_CORE_DIV);
      default:              freq_of = 32'(SUB_HZ);
    endcase
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_hit = (awaddr_q == CTRL_OFFSET) || (awaddr_q == FLASH_OFFSET) ||
                  (awaddr_q == POWER_OFFSET) || (awaddr_q == STATUS_OFFSET);

  // Address and data are taken in either order and held until both are in.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response follows the completed write; unmapped offsets answer SLVERR.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Software settings.
  // ****************************************************************
  // Control word; reset picks the PLL with the main oscillator running.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
    end else if (wr_fire && awaddr_q == CTRL_OFFSET) begin
      ctrl_q <= ctrl_t'((ctrl_q & ~(wmask[8:0] & CTRL_WR_MASK)) |
                        (wdata_q[8:0] & wmask[8:0] & CTRL_WR_MASK));
    end
  end

  // Requested flash wait setting; the reserved code three is kept out.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flash_req_q <= FLASH_TWO_WAIT_CODE;
    end else if (wr_fire && awaddr_q == FLASH_OFFSET && wstrb_q[0]) begin
      flash_req_q <= (wdata_q[1:0] == 2'h3) ? FLASH_TWO_WAIT_CODE : wdata_q[1:0];
    end
  end

  // ****************************************************************
  // Oscillator enables and stabilization.
  // ****************************************************************
  // The active source is never stopped; the PLL keeps its main input alive.
  always_comb begin
    osc_on[SOURCE_CODE_PLL]      = ctrl_q.pll_en || active_q == SOURCE_CODE_PLL;
    osc_on[SOURCE_CODE_MAIN]     = ctrl_q.main_en || active_q == SOURCE_CODE_MAIN ||
                                   osc_on[SOURCE_CODE_PLL];
    osc_on[SOURCE_CODE_FAST_OSC] = ctrl_q.fast_en || active_q == SOURCE_CODE_FAST_OSC;
    osc_on[SOURCE_CODE_SUB]      = ctrl_q.sub_req || ctrl_q.rtc_req ||
                                   active_q == SOURCE_CODE_SUB;
  end

  // Registered oscillator enables and fixed PLL ratio.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_osc_en                 <= 1'b0;
      pll_en                      <= 1'b0;
      internal_fast_oscillator_en <= 1'b0;
      sub_osc_en                  <= 1'b0;
      pll_in_div                  <= PLL_IN_DIV_CODE;
      pll_mult                    <= PLL_MULT_CODE;
    end else begin
      main_osc_en                 <= osc_on[SOURCE_CODE_MAIN];
      pll_en                      <= osc_on[SOURCE_CODE_PLL] && stable[SOURCE_CODE_MAIN];
      internal_fast_oscillator_en <= osc_on[SOURCE_CODE_FAST_OSC];
      sub_osc_en                  <= osc_on[SOURCE_CODE_SUB];
      pll_in_div                  <= PLL_IN_DIV_CODE;
      pll_mult                    <= PLL_MULT_CODE;
    end
  end

  localparam int unsigned STAB_CNT [4] = '{MAIN_STAB, FAST_STAB, PLL_STAB, SUB_STAB};

  // One stabilization wait per source, indexed by its source code.
  for (genvar i = 0; i < 4; i++) begin : g_stab
    logic run;
    assign run = (i == 0) ? main_osc_en : (i == 1) ? internal_fast_oscillator_en :
                 (i == 2) ? pll_en : sub_osc_en;
    osc_stab_timer #(
      .COUNT (STAB_CNT[i])
    ) u_timer (
      .clk    (clk),
      .nrst   (nrst),
      .run    (run),
      .stable (stable[i])
    );
  end

  // ****************************************************************
  // Source switching.
  // ****************************************************************
  // Waits for the requested source to settle, then moves onto it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_q     <= SW_WAIT;
      active_q <= SOURCE_CODE_MAIN;
    end else begin
      case (sw_q)
        SW_IDLE: begin
          if (ctrl_q.src != active_q) begin
            sw_q <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (ctrl_q.src == active_q) begin
            sw_q <= SW_IDLE;
          end else if (stable[ctrl_q.src]) begin
            active_q <= ctrl_q.src;
            sw_q     <= SW_IDLE;
          end
        end
        default: begin
          sw_q <= SW_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flash wait and power mode.
  // ****************************************************************
  // Sized for the faster of the running and the requested source.
  assign target_hz = (freq_of(ctrl_q.src) > freq_of(active_q)) ?
                     freq_of(ctrl_q.src) : freq_of(active_q);

  // Smallest legal wait at the target frequency, raised to what software asked.
  always_comb begin
    if (target_hz >= 32'(TWO_WAIT_MIN_HZ)) begin
      flash_need = FLASH_TWO_WAIT_CODE;
    end else if (target_hz >= 32'(ZERO_WAIT_MAX_HZ) &&
                 flash_req_q == FLASH_ZERO_WAIT_CODE) begin
      flash_need = FLASH_ONE_WAIT_CODE;
    end else begin
      flash_need = flash_req_q;
    end
  end

  // Applied wait setting, power mode and running core frequency.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flash_wait_setting   <= FLASH_TWO_WAIT_CODE;
      power_mode_setting   <= HIGH_SPEED_POWER_CODE;
      system_source_select <= SOURCE_CODE_MAIN;
      core_system_clock_hz <= 32'h0;
    end else begin
      flash_wait_setting   <= flash_need;
      power_mode_setting   <= (active_q == SOURCE_CODE_MAIN || active_q == SOURCE_CODE_SUB) ?
                              LOW_SPEED_ONE_POWER_CODE : HIGH_SPEED_POWER_CODE;
      system_source_select <= active_q;
      core_system_clock_hz <= freq_of(active_q);
    end
  end

  // Sticky flag for a refused wait request; a new refusal beats the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      viol_q <= 1'b0;
    end else if (flash_need != flash_req_q) begin
      viol_q <= 1'b1;
    end else if (wr_fire && awaddr_q == STATUS_OFFSET && wstrb_q[0] && wdata_q[VIOL_BIT]) begin
      viol_q <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  assign status = '{viol: viol_q, pending: (sw_q == SW_WAIT), stable: stable, active: active_q};
  assign s_axi_arready = !s_axi_rvalid;

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (s_axi_araddr)
      CTRL_OFFSET:   rd_word = {23'h0, ctrl_q};
      FLASH_OFFSET:  rd_word = {28'h0, flash_wait_setting, flash_req_q};
      POWER_OFFSET:  rd_word = {30'h0, power_mode_setting};
      STATUS_OFFSET: rd_word = {24'h0, status};
      default:       rd_hit  = 1'b0;
    endcase
  end

  // Read data are registered at the same edge that takes the address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- system_clock_source_select_checker.sv
`timescale 1ns/1ps
module system_clock_source_select_checker
  import clk_sel_pkg::*;
#(
  parameter int unsigned PLL_STAB  = 16,
  parameter int unsigned FAST_STAB = 16
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        main_osc_en,
  input wire logic        pll_en,
  input wire logic [3:0]  pll_in_div,
  input wire logic [5:0]  pll_mult,
  input wire logic        internal_fast_oscillator_en,
  input wire logic        sub_osc_en,
  input wire logic [1:0]  system_source_select,
  input wire logic [1:0]  power_mode_setting,
  input wire logic [1:0]  flash_wait_setting,
  input wire logic [31:0] core_system_clock_hz
);
  // ********
  // Run-time counters.
  // ********
  logic [15:0] pll_on_q;
  logic [15:0] fast_on_q;

  // Counts how long the PLL enable has stood high, saturating.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pll_on_q <= 16'h0000;
    else if (!pll_en) pll_on_q <= 16'h0000;
    else if (pll_on_q != 16'hffff) pll_on_q <= pll_on_q + 16'h0001;
  end

  // Counts how long the fast oscillator enable has stood high, saturating.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fast_on_q <= 16'h0000;
    else if (!internal_fast_oscillator_en) fast_on_q <= 16'h0000;
    else if (fast_on_q != 16'hffff) fast_on_q <= fast_on_q + 16'h0001;
  end

  // ********
  // Properties.
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  two_wait_a:
    assert property ((core_system_clock_hz >= TWO_WAIT_MIN_HZ) && $stable(core_system_clock_hz)
      |-> flash_wait_setting == FLASH_TWO_WAIT_CODE) else $error("two waits missing");
  zero_wait_a:
    assert property ((core_system_clock_hz >= ZERO_WAIT_MAX_HZ) && $stable(core_system_clock_hz)
      |-> flash_wait_setting != FLASH_ZERO_WAIT_CODE) else $error("zero wait at high clock");
  sub_run_a:
    assert property (system_source_select == SOURCE_CODE_SUB |-> sub_osc_en)
      else $error("sub source without sub oscillator");
  pll_ratio_a:
    assert property (pll_en |-> pll_in_div == PLL_IN_DIV_CODE && pll_mult == PLL_MULT_CODE)
      else $error("pll ratio wrong");
  pll_main_a:
    assert property (pll_en |-> main_osc_en) else $error("pll runs without main");
  pll_hz_a:
    assert property (system_source_select == SOURCE_CODE_PLL ##1 $stable(system_source_select)
      |-> core_system_clock_hz == MAIN_HZ * PLL_MULT / PLL_IN_DIV / PLL_CORE_DIV)
      else $error("pll core frequency wrong");
  power_mode_a:
    assert property ($stable(system_source_select) && $past(nrst) |-> power_mode_setting ==
      ((system_source_select == SOURCE_CODE_MAIN || system_source_select == SOURCE_CODE_SUB)
      ? LOW_SPEED_ONE_POWER_CODE : HIGH_SPEED_POWER_CODE)) else $error("power mode wrong");
  pll_wait_a:
    assert property ($changed(system_source_select) && system_source_select == SOURCE_CODE_PLL
      |-> pll_on_q >= PLL_STAB) else $error("switch to pll before stable");
  fast_wait_a:
    assert property ($changed(system_source_select) && system_source_select ==
      SOURCE_CODE_FAST_OSC |-> fast_on_q >= FAST_STAB) else $error("switch to fast too early");
endmodule

bind system_clock_source_select system_clock_source_select_checker #(
  .PLL_STAB(PLL_STAB), .FAST_STAB(FAST_STAB)
) chk_u (
  .clk(clk), .nrst(nrst), .main_osc_en(main_osc_en), .pll_en(pll_en),
  .pll_in_div(pll_in_div), .pll_mult(pll_mult), .sub_osc_en(sub_osc_en),
  .internal_fast_oscillator_en(internal_fast_oscillator_en),
  .system_source_select(system_source_select), .power_mode_setting(power_mode_setting),
  .flash_wait_setting(flash_wait_setting), .core_system_clock_hz(core_system_clock_hz)
);

//--- system_clock_source_select_bench.sv
`timescale 1ns/1ps
module system_clock_source_select_bench;
  import clk_sel_pkg::*;
  localparam int unsigned MST = 8;
  localparam int unsigned FST = 6;
  logic        clk;
  logic        nrst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        main_en;
  logic        pll_en;
  logic [3:0]  pll_div;
  logic [5:0]  pll_mul;
  logic        fast_en;
  logic        sub_en;
  logic [1:0]  src;
  logic [1:0]  power;
  logic [1:0]  flash;
  logic [31:0] hz;
  logic [31:0] rd;
  logic [1:0]  resp;
  int          n_errors;
  int          compares;
  int          waited;

  // Design with short stabilization counts.
  system_clock_source_select #(
    .MAIN_STAB(MST), .SUB_STAB(12), .PLL_STAB(6), .FAST_STAB(FST)
  ) dut_u (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_osc_en(main_en), .pll_en(pll_en), .pll_in_div(pll_div), .pll_mult(pll_mul),
    .internal_fast_oscillator_en(fast_en), .sub_osc_en(sub_en),
    .system_source_select(src), .power_mode_setting(power),
    .flash_wait_setting(flash), .core_system_clock_hz(hz)
  );

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // ********
  // Shared tasks.
  // ********
  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops.
  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Register write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Register read; the answer is taken at the edge that shows rvalid.
  task automatic rd_reg(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Waits, bounded, for the active source to become the given code.
  task automatic wait_src(input logic [1:0] code);
    waited = 0;
    while (src !== code && waited < 2000) begin
      @(posedge clk);
      waited++;
    end
    @(negedge clk);
    check(waited < 2000, 1'b1);
  endtask

  // Lets registered outputs follow a register write.
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // ********
  // Main sequence.
  // ********
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    settle();
    check(main_en, 1'b1);
    check(fast_en, 1'b0);
    check(sub_en, 1'b0);
    rd_reg(CTRL_OFFSET);
    check(rd, 32'h0000_0032);
    wait_src(SOURCE_CODE_PLL);
    check(src, SOURCE_CODE_PLL);
    check(hz, MAIN_HZ * PLL_MULT / PLL_IN_DIV / PLL_CORE_DIV);
    check(pll_div, PLL_IN_DIV_CODE);
    check(pll_mul, PLL_MULT_CODE);
    check(power, HIGH_SPEED_POWER_CODE);
    check(flash, FLASH_TWO_WAIT_CODE);
    // A zero-wait request at the PLL clock is overridden and flagged.
    wr(FLASH_OFFSET, 32'h0000_0000);
    settle();
    check(flash, FLASH_TWO_WAIT_CODE);
    rd_reg(FLASH_OFFSET);
    check(rd, 32'h0000_0008);
    rd_reg(STATUS_OFFSET);
    check(rd[7], 1'b1);
    wr(FLASH_OFFSET, 32'h0000_0002);
    wr(STATUS_OFFSET, 32'h0000_0080);
    rd_reg(STATUS_OFFSET);
    check(rd[7], 1'b0);
    // Every combination of the two sub-clock requests under the PLL.
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFFSET, 32'h0000_0032 | (32'(i) << 7));
      settle();
      check(sub_en, i != 0);
      check(src, SOURCE_CODE_PLL);
    end
    // Switch to the fast oscillator only after its count has run out.
    wr(CTRL_OFFSET, 32'h0000_0041);
    @(negedge clk);
    check(src, SOURCE_CODE_PLL);
    wait_src(SOURCE_CODE_FAST_OSC);
    check(waited >= FST, 1'b1);
    check(power, HIGH_SPEED_POWER_CODE);
    check(hz, FAST_OSC_HZ);
    wr(FLASH_OFFSET, 32'h0000_0000);
    settle();
    check(flash, FLASH_ZERO_WAIT_CODE);
    rd_reg(STATUS_OFFSET);
    check(rd[7], 1'b0);
    // Main oscillator as source gives low-speed mode one.
    wr(CTRL_OFFSET, 32'h0000_0010);
    wait_src(SOURCE_CODE_MAIN);
    check(waited >= MST, 1'b1);
    check(power, LOW_SPEED_ONE_POWER_CODE);
    check(hz, MAIN_HZ / MAIN_CORE_DIV);
    // Sub-clock as source keeps it running.
    wr(CTRL_OFFSET, 32'h0000_0093);
    wait_src(SOURCE_CODE_SUB);
    check(sub_en, 1'b1);
    check(power, LOW_SPEED_ONE_POWER_CODE);
    check(hz, SUB_HZ);
    // Unmapped offset is refused both ways and leaves the sub-clock running.
    wr(8'h20, 32'hffff_ffff);
    check(resp, RESP_SLVERR);
    rd_reg(8'h20);
    check(rd, 32'h0000_0000);
    check(resp, RESP_SLVERR);
    check(sub_en, 1'b1);
    test_done();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200_000;
    n_errors++;
    test_done();
  end
endmodule
